// File: core/omr_mixer_regs.sv
// Select and attenuation register pair for one analogue output mixer.
`timescale 1ns/10ps
`default_nettype none

module omr_mixer_regs
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        select_wr,
  input  wire logic        atten_wr,
  input  wire logic [15:0] wdata,
  output logic [6:0]       select_q,
  output logic [6:0]       path_cut_q,
  output logic [15:0]      select_rd,
  output logic [15:0]      atten_rd
);

  // ==========================================================================
  // State
  // ==========================================================================
  omr_pkg::omr_mix_s state_q;
  omr_pkg::omr_mix_s state_d;

  // Only the seven source bits and five attenuation bits are stored; the rest of a write is dropped.
  always_comb
  begin
    state_d = state_q;
    if (select_wr)
    begin
      state_d.select = wdata[6:0];
    end
    if (atten_wr)
    begin
      state_d.atten = {wdata[omr_pkg::BIT_SRC_BYPASS],
                       wdata[omr_pkg::BIT_SRC_LDAC],
                       wdata[omr_pkg::BIT_SRC_RDAC],
                       wdata[omr_pkg::BIT_SRC_AUX2],
                       wdata[omr_pkg::BIT_SRC_AUX1]};
    end
  end

  // Register the whole state; all sources disabled and at 0dB after reset.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q.select <= omr_pkg::RST_MIXER_SELECT;
      state_q.atten  <= omr_pkg::RST_MIXER_ATTEN;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // One DAC attenuation bit drives both the direct and the inverted path from that DAC.
  assign select_q   = state_q.select;
  assign path_cut_q = {state_q.atten[4],
                       state_q.atten[3],
                       state_q.atten[2],
                       state_q.atten[3],
                       state_q.atten[2],
                       state_q.atten[1],
                       state_q.atten[0]};

  // Read views; bits without a field read as zero.
  assign select_rd = {9'h000, state_q.select};
  assign atten_rd  = {9'h000, state_q.atten[4], 2'b00, state_q.atten[3:0]};

endmodule

`default_nettype wire

// File: core/omr_output_mixer_ctrl.sv
// Control register bank for the line output and speaker PGA mixers: enables, mutes, sources and attenuation.
//
// Overview of operation
// - Power register bit 3 enables right speaker mixer.
// - Power register bit 2 enables left speaker mixer.
// - Output register bits 8/9 mute left/right line.
// - All mixer and line mutes reset muted.
// - Left line select: bypass, inverted DACs, DACs, aux.
// - Left line attenuation bits choose -6dB per source.
// - Right line select uses same seven-bit layout.
// - Right line attenuation bits choose -6dB per source.
// - DAC attenuation covers direct and inverted paths.
// - Power register bits 4/5 mute speaker mixers.
// - Left speaker select uses seven-bit source layout.
// - Left speaker attenuation bits choose -6dB per source.
// - Right speaker select uses same seven-bit layout.
// - Right speaker attenuation bits choose -6dB per source.
`timescale 1ns/10ps
`default_nettype none

module omr_output_mixer_ctrl
(
  input  wire logic        SYS_CLK,
  input  wire logic        ARST_N,
  input  wire logic [6:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [15:0]      REG_RDATA,
  output logic             REG_RVALID,
  output logic             LEFT_SPK_MIXER_ON,
  output logic             RIGHT_SPK_MIXER_ON,
  output logic             LEFT_SPK_MIXER_SILENCE,
  output logic             RIGHT_SPK_MIXER_SILENCE,
  output logic             LEFT_LINE_OUT_SILENCE,
  output logic             RIGHT_LINE_OUT_SILENCE,
  output logic [6:0]       LEFT_LINE_MIXER_SRC,
  output logic [6:0]       LEFT_LINE_MIXER_CUT,
  output logic [6:0]       RIGHT_LINE_MIXER_SRC,
  output logic [6:0]       RIGHT_LINE_MIXER_CUT,
  output logic [6:0]       LEFT_SPK_MIXER_SRC,
  output logic [6:0]       LEFT_SPK_MIXER_CUT,
  output logic [6:0]       RIGHT_SPK_MIXER_SRC,
  output logic [6:0]       RIGHT_SPK_MIXER_CUT
);

  // ==========================================================================
  // Per-mixer register pairs
  // ==========================================================================
  logic [3:0][6:0]  mix_src;
  logic [3:0][6:0]  mix_cut;
  logic [3:0][15:0] mix_sel_rd;
  logic [3:0][15:0] mix_att_rd;
  logic [3:0]       mix_sel_hit;
  logic [3:0]       mix_att_hit;

  // One register pair per mixer, picked out by its own pair of addresses.
  genvar gi;
  generate
    for (gi = 0; gi < omr_pkg::NUM_MIXERS; gi++)
    begin : g_mixer
      assign mix_sel_hit[gi] = (REG_ADDR == omr_pkg::ADDR_MIXER_SELECT[gi]);
      assign mix_att_hit[gi] = (REG_ADDR == omr_pkg::ADDR_MIXER_ATTEN[gi]);

      omr_mixer_regs u_regs
      (
        .clk        (SYS_CLK),
        .arst_n     (ARST_N),
        .select_wr  (REG_WR && mix_sel_hit[gi]),
        .atten_wr   (REG_WR && mix_att_hit[gi]),
        .wdata      (REG_WDATA),
        .select_q   (mix_src[gi]),
        .path_cut_q (mix_cut[gi]),
        .select_rd  (mix_sel_rd[gi]),
        .atten_rd   (mix_att_rd[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Enable, mute and read state
  // ==========================================================================
  omr_pkg::omr_top_s state_q;
  omr_pkg::omr_top_s state_d;
  logic              hit_power;
  logic              hit_mutes;

  assign hit_power = (REG_ADDR == omr_pkg::ADDR_OUTPUT_POWER_ENABLES);
  assign hit_mutes = (REG_ADDR == omr_pkg::ADDR_LINE_OUTPUT_MUTES);

  // Writes update only the listed fields; a read is answered one cycle later from the
  // values held before any write in the same cycle, so a read never sees a half-taken write.
  always_comb
  begin
    state_d            = state_q;
    state_d.read_valid = REG_RD;
    if (REG_WR && hit_power)
    begin
      state_d.right_spk_mixer_on      = REG_WDATA[omr_pkg::BIT_RIGHT_SPK_MIXER_ON];
      state_d.left_spk_mixer_on       = REG_WDATA[omr_pkg::BIT_LEFT_SPK_MIXER_ON];
      state_d.left_spk_mixer_silence  = REG_WDATA[omr_pkg::BIT_LEFT_SPK_MIXER_SILENCE];
      state_d.right_spk_mixer_silence = REG_WDATA[omr_pkg::BIT_RIGHT_SPK_MIXER_SILENCE];
    end
    if (REG_WR && hit_mutes)
    begin
      state_d.left_line_out_silence  = REG_WDATA[omr_pkg::BIT_LEFT_LINE_OUT_SILENCE];
      state_d.right_line_out_silence = REG_WDATA[omr_pkg::BIT_RIGHT_LINE_OUT_SILENCE];
    end
    if (REG_RD)
    begin
      state_d.read_data = omr_pkg::RST_READ_DATA;
      if (hit_power)
      begin
        state_d.read_data[omr_pkg::BIT_RIGHT_SPK_MIXER_ON]      = state_q.right_spk_mixer_on;
        state_d.read_data[omr_pkg::BIT_LEFT_SPK_MIXER_ON]       = state_q.left_spk_mixer_on;
        state_d.read_data[omr_pkg::BIT_LEFT_SPK_MIXER_SILENCE]  = state_q.left_spk_mixer_silence;
        state_d.read_data[omr_pkg::BIT_RIGHT_SPK_MIXER_SILENCE] = state_q.right_spk_mixer_silence;
      end
      if (hit_mutes)
      begin
        state_d.read_data[omr_pkg::BIT_LEFT_LINE_OUT_SILENCE]  = state_q.left_line_out_silence;
        state_d.read_data[omr_pkg::BIT_RIGHT_LINE_OUT_SILENCE] = state_q.right_line_out_silence;
      end
      for (int i = 0; i < omr_pkg::NUM_MIXERS; i++)
      begin
        if (mix_sel_hit[i])
        begin
          state_d.read_data = mix_sel_rd[i];
        end
        if (mix_att_hit[i])
        begin
          state_d.read_data = mix_att_rd[i];
        end
      end
    end
  end

  // Everything is silent and the speaker mixers are off after reset.
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_q.left_spk_mixer_on       <= omr_pkg::RST_SPK_MIXER_ON;
      state_q.right_spk_mixer_on      <= omr_pkg::RST_SPK_MIXER_ON;
      state_q.left_spk_mixer_silence  <= omr_pkg::RST_SPK_MIXER_SILENCE;
      state_q.right_spk_mixer_silence <= omr_pkg::RST_SPK_MIXER_SILENCE;
      state_q.left_line_out_silence   <= omr_pkg::RST_LINE_OUT_SILENCE;
      state_q.right_line_out_silence  <= omr_pkg::RST_LINE_OUT_SILENCE;
      state_q.read_data               <= omr_pkg::RST_READ_DATA;
      state_q.read_valid              <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Static levels into the analogue fabric. Enabling a mixer does not check the reference or
  // bias state; software owns that ordering.
  assign REG_RDATA               = state_q.read_data;
  assign REG_RVALID              = state_q.read_valid;
  assign LEFT_SPK_MIXER_ON       = state_q.left_spk_mixer_on;
  assign RIGHT_SPK_MIXER_ON      = state_q.right_spk_mixer_on;
  assign LEFT_SPK_MIXER_SILENCE  = state_q.left_spk_mixer_silence;
  assign RIGHT_SPK_MIXER_SILENCE = state_q.right_spk_mixer_silence;
  assign LEFT_LINE_OUT_SILENCE   = state_q.left_line_out_silence;
  assign RIGHT_LINE_OUT_SILENCE  = state_q.right_line_out_silence;
  assign LEFT_LINE_MIXER_SRC     = mix_src[0];
  assign LEFT_LINE_MIXER_CUT     = mix_cut[0];
  assign RIGHT_LINE_MIXER_SRC    = mix_src[1];
  assign RIGHT_LINE_MIXER_CUT    = mix_cut[1];
  assign LEFT_SPK_MIXER_SRC      = mix_src[2];
  assign LEFT_SPK_MIXER_CUT      = mix_cut[2];
  assign RIGHT_SPK_MIXER_SRC     = mix_src[3];
  assign RIGHT_SPK_MIXER_CUT     = mix_cut[3];

endmodule

`default_nettype wire

// File: inc/omr_pkg.sv
// Package of addresses, field positions, reset values and state types for the output mixer control bank.
`default_nettype none

package omr_pkg;

  // ==========================================================================
  // Register addresses on the control port
  // ==========================================================================
  localparam logic [6:0] ADDR_OUTPUT_POWER_ENABLES = 7'h03;
  localparam logic [6:0] ADDR_LINE_OUTPUT_MUTES    = 7'h2a;

  // Mixer order in every per-mixer table: 0 left line, 1 right line, 2 left speaker, 3 right speaker.
  localparam int unsigned NUM_MIXERS = 4;
  localparam logic [3:0][6:0] ADDR_MIXER_SELECT = {7'h2c, 7'h2b, 7'h32, 7'h31};
  localparam logic [3:0][6:0] ADDR_MIXER_ATTEN  = {7'h2e, 7'h2d, 7'h34, 7'h33};

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned BIT_LEFT_SPK_MIXER_ON       = 2;
  localparam int unsigned BIT_RIGHT_SPK_MIXER_ON      = 3;
  localparam int unsigned BIT_LEFT_SPK_MIXER_SILENCE  = 4;
  localparam int unsigned BIT_RIGHT_SPK_MIXER_SILENCE = 5;
  localparam int unsigned BIT_LEFT_LINE_OUT_SILENCE   = 8;
  localparam int unsigned BIT_RIGHT_LINE_OUT_SILENCE  = 9;

  // Source positions in the select registers of all four mixers; the attenuation registers use all but the two inverted-DAC ones.
  localparam int unsigned BIT_SRC_BYPASS   = 6;
  localparam int unsigned BIT_SRC_INV_LDAC = 5;
  localparam int unsigned BIT_SRC_INV_RDAC = 4;
  localparam int unsigned BIT_SRC_LDAC     = 3;
  localparam int unsigned BIT_SRC_RDAC     = 2;
  localparam int unsigned BIT_SRC_AUX2     = 1;
  localparam int unsigned BIT_SRC_AUX1     = 0;

  // ==========================================================================
  // Values after reset
  // ==========================================================================
  localparam logic       RST_SPK_MIXER_ON      = 1'b0;
  localparam logic       RST_SPK_MIXER_SILENCE = 1'b1;
  localparam logic       RST_LINE_OUT_SILENCE  = 1'b1;
  localparam logic [6:0] RST_MIXER_SELECT      = 7'h00;
  localparam logic [4:0] RST_MIXER_ATTEN       = 5'h00;
  localparam logic [15:0] RST_READ_DATA        = 16'h0000;

  // ==========================================================================
  // State types
  // ==========================================================================
  // Attenuation bits held packed as {bypass, left dac, right dac, aux2, aux1}.
  typedef struct packed {
    logic [6:0] select;
    logic [4:0] atten;
  } omr_mix_s;

  typedef struct packed {
    logic        left_spk_mixer_on;
    logic        right_spk_mixer_on;
    logic        left_spk_mixer_silence;
    logic        right_spk_mixer_silence;
    logic        left_line_out_silence;
    logic        right_line_out_silence;
    logic [15:0] read_data;
    logic        read_valid;
  } omr_top_s;

endpackage

`default_nettype wire

// File: testbench/omr_checker.sv
// Concurrent checks on the register port and the mixer control outputs.
`timescale 1ns/10ps
`default_nettype none

module omr_checker
(
  input wire logic        SYS_CLK,
  input wire logic        ARST_N,
  input wire logic [6:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic        REG_RVALID,
  input wire logic        LEFT_SPK_MIXER_ON,
  input wire logic        RIGHT_SPK_MIXER_ON,
  input wire logic        LEFT_SPK_MIXER_SILENCE,
  input wire logic        RIGHT_SPK_MIXER_SILENCE,
  input wire logic        LEFT_LINE_OUT_SILENCE,
  input wire logic        RIGHT_LINE_OUT_SILENCE,
  input wire logic [6:0]  LEFT_LINE_MIXER_SRC,
  input wire logic [6:0]  LEFT_LINE_MIXER_CUT,
  input wire logic [6:0]  RIGHT_SPK_MIXER_CUT
);
  // ==========
  // One clock domain, so clocking and reset are given once for all checks.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  rd_answer_a: assert property (REG_RD |=> REG_RVALID) else $error("read not answered in the next cycle");
  rd_single_a: assert property (!REG_RD |=> !REG_RVALID) else $error("read valid without a read");
  power_field_a: assert property (
    REG_WR && REG_ADDR == 7'h03 |=> {RIGHT_SPK_MIXER_SILENCE, LEFT_SPK_MIXER_SILENCE, RIGHT_SPK_MIXER_ON,
    LEFT_SPK_MIXER_ON} == $past(REG_WDATA[5:2])) else $error("power bits not taken from the write");
  line_mute_a: assert property (
    REG_WR && REG_ADDR == 7'h2a |=> {RIGHT_LINE_OUT_SILENCE, LEFT_LINE_OUT_SILENCE} == $past(REG_WDATA[9:8]))
    else $error("line mutes not taken from the write");
  line_select_a: assert property (
    REG_WR && REG_ADDR == 7'h31 |=> LEFT_LINE_MIXER_SRC == $past(REG_WDATA[6:0])) else $error("select wrong");
  spk_atten_a: assert property (
    REG_WR && REG_ADDR == 7'h2e |=> RIGHT_SPK_MIXER_CUT == {$past(REG_WDATA[6]), $past(REG_WDATA[3:2]),
    $past(REG_WDATA[3:0])}) else $error("speaker cut vector wrong");
  inv_path_cut_a: assert property (LEFT_LINE_MIXER_CUT[5:4] == LEFT_LINE_MIXER_CUT[3:2])
    else $error("inverted path cut differs from direct path");
  ctrl_hold_a: assert property (
    !REG_WR |=> $stable({LEFT_SPK_MIXER_ON, RIGHT_SPK_MIXER_SILENCE, LEFT_LINE_OUT_SILENCE, LEFT_LINE_MIXER_SRC}))
    else $error("control output moved without a write");
  unmapped_read_a: assert property (REG_RD && REG_ADDR == 7'h00 |=> REG_RDATA == 16'h0000)
    else $error("unmapped read not zero");
endmodule

bind omr_output_mixer_ctrl omr_checker u_omr_checker
(
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .LEFT_SPK_MIXER_ON(LEFT_SPK_MIXER_ON),
  .RIGHT_SPK_MIXER_ON(RIGHT_SPK_MIXER_ON), .LEFT_SPK_MIXER_SILENCE(LEFT_SPK_MIXER_SILENCE),
  .RIGHT_SPK_MIXER_SILENCE(RIGHT_SPK_MIXER_SILENCE), .LEFT_LINE_OUT_SILENCE(LEFT_LINE_OUT_SILENCE),
  .RIGHT_LINE_OUT_SILENCE(RIGHT_LINE_OUT_SILENCE), .LEFT_LINE_MIXER_SRC(LEFT_LINE_MIXER_SRC),
  .LEFT_LINE_MIXER_CUT(LEFT_LINE_MIXER_CUT), .RIGHT_SPK_MIXER_CUT(RIGHT_SPK_MIXER_CUT)
);

`default_nettype wire

// File: testbench/omr_host_model.sv
// Host processor model that drives the register port with single write and read cycles.
`timescale 1ns/10ps
`default_nettype none

module omr_host_model
(
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid,
  output var logic [6:0]   addr,
  output var logic [15:0]  wdata,
  output var logic         wr,
  output var logic         rd
);
  // ==========
  // Idle port from time zero; reference and bias sit outside this bank and are taken as already on.
  initial
  begin
    addr = 7'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One write strobe; returns just after the taking edge so outputs have settled.
  task automatic write_reg(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // One read strobe; the answer stands for exactly the cycle after the taking edge.
  task automatic read_reg(input logic [6:0] a, output logic [15:0] d, output logic v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    v = rvalid;
  endtask
endmodule

`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the output mixer control bank.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("BAD %0t %h %h", $time, (g), (e)); end end

module tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [6:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] got;
  logic        wr;
  logic        rd;
  logic        rvalid;
  logic        v;
  logic [5:0]  ctl;
  logic [6:0]  src [4];
  logic [6:0]  cut [4];
  int          fails = 0;
  int          n_tests = 0;

  // ==========
  // 125 MHz clock.
  initial
  begin
    forever #4 clk = ~clk;
  end

  omr_output_mixer_ctrl u_omr_output_mixer_ctrl
  (
    .SYS_CLK(clk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .LEFT_SPK_MIXER_ON(ctl[5]), .RIGHT_SPK_MIXER_ON(ctl[4]),
    .LEFT_SPK_MIXER_SILENCE(ctl[3]), .RIGHT_SPK_MIXER_SILENCE(ctl[2]), .LEFT_LINE_OUT_SILENCE(ctl[1]),
    .RIGHT_LINE_OUT_SILENCE(ctl[0]), .LEFT_LINE_MIXER_SRC(src[0]), .LEFT_LINE_MIXER_CUT(cut[0]),
    .RIGHT_LINE_MIXER_SRC(src[1]), .RIGHT_LINE_MIXER_CUT(cut[1]), .LEFT_SPK_MIXER_SRC(src[2]),
    .LEFT_SPK_MIXER_CUT(cut[2]), .RIGHT_SPK_MIXER_SRC(src[3]), .RIGHT_SPK_MIXER_CUT(cut[3])
  );

  omr_host_model u_omr_host_model
  (
    .clk(clk), .rdata(rdata), .rvalid(rvalid), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd)
  );

  // Reads a register and checks both the data and that valid is set just after the taking edge.
  task automatic rchk(input logic [6:0] a, input logic [15:0] e);
    u_omr_host_model.read_reg(a, got, v);
    `CHK({v, got}, {1'b1, e})
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========
  // Main sequence: reset values, field mapping per mixer, unmapped space, then a reset in mid-run.
  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(ctl, 6'b001111)
    rchk(7'h03, 16'h0030);
    rchk(7'h2a, 16'h0300);
    for (int i = 0; i < 4; i++)
    begin
      rchk(omr_pkg::ADDR_MIXER_SELECT[i], 16'h0000);
      rchk(omr_pkg::ADDR_MIXER_ATTEN[i], 16'h0000);
      u_omr_host_model.write_reg(omr_pkg::ADDR_MIXER_SELECT[i], 16'hffff);
      `CHK(src[i], 7'h7f)
      rchk(omr_pkg::ADDR_MIXER_SELECT[i], 16'h007f);
      u_omr_host_model.write_reg(omr_pkg::ADDR_MIXER_SELECT[i], 16'h0035);
      u_omr_host_model.write_reg(omr_pkg::ADDR_MIXER_ATTEN[i], 16'hffff);
      `CHK(cut[i], 7'h7f)
      rchk(omr_pkg::ADDR_MIXER_ATTEN[i], 16'h004f);
      u_omr_host_model.write_reg(omr_pkg::ADDR_MIXER_ATTEN[i], 16'h0008);
      `CHK(cut[i], 7'h28)
      u_omr_host_model.write_reg(omr_pkg::ADDR_MIXER_ATTEN[i], 16'h0045);
      `CHK(cut[i], 7'h55)
    end
    `CHK({src[0], src[1], src[2], src[3]}, {4{7'h35}})
    u_omr_host_model.write_reg(7'h03, 16'hffff);
    `CHK(ctl, 6'b111111)
    rchk(7'h03, 16'h003c);
    u_omr_host_model.write_reg(7'h03, 16'h0014);
    u_omr_host_model.write_reg(7'h2a, 16'hfdff);
    `CHK(ctl, 6'b101010)
    rchk(7'h2a, 16'h0100);
    u_omr_host_model.write_reg(7'h00, 16'hffff);
    rchk(7'h00, 16'h0000);
    rchk(7'h7f, 16'h0000);
    rchk(7'h03, 16'h0014);
    // A reset in mid-run must bring back the muted, all-off state.
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({ctl, src[1], cut[3]}, {6'b001111, 14'h0000})
    @(posedge clk);
    arst_n <= 1'b1;
    // The first read and write after the release must work at once.
    rchk(7'h03, 16'h0030);
    u_omr_host_model.write_reg(7'h2a, 16'h0000);
    `CHK(ctl, 6'b001100)
    final_report;
  end

  // Watchdog: the sequence needs well under a thousand cycles.
  initial
  begin
    repeat (4000) @(posedge clk);
    fails++;
    final_report;
  end
endmodule

`default_nettype wire
